// ---- inc/wake_pkg.sv ----
package wake_pkg;

  // ==========================================================================
  // Sizes
  localparam int FILT_N    = 6;
  localparam int WS_W      = FILT_N + 2;
  localparam int LEN_W     = 14;
  localparam int MEM_BYTES = 128;
  localparam int MEM_AW    = 7;
  localparam int MAC_W     = 48;

  // ==========================================================================
  // Wake status and wake filter control bit positions
  localparam int WS_LINK_CHANGE_WAKE  = 0;
  localparam int WS_MAGIC = 1;
  localparam int WS_FILT0 = 2;

  // ==========================================================================
  // Magic pattern
  localparam logic [7:0] SYNC_BYTE  = 8'hff;
  localparam logic [2:0] SYNC_COUNT = 3'h6;
  localparam logic [2:0] MAC_LAST   = 3'h5;
  localparam logic [3:0] REPS_LAST  = 4'hf;

  // ==========================================================================
  // Power states and reset values
  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D3 = 2'h3;
  localparam logic [LEN_W-1:0] LEN_RESET = 14'h0000;
  localparam logic [WS_W-1:0]  WS_RESET  = 8'h00;
  localparam logic [LEN_W-1:0] LEN_MAX   = 14'h3fff;

  typedef enum logic [0:0] {
    MG_SYNC = 1'b0,
    MG_ADDR = 1'b1
  } magic_state_e;

  typedef enum logic [2:0] {
    CMD_CTRL       = 3'b000,
    CMD_PME_EN     = 3'b001,
    CMD_ARM        = 3'b010,
    CMD_DISARM     = 3'b011,
    CMD_CLR_PME    = 3'b100,
    CMD_CLR_STATUS = 3'b101,
    CMD_POWER      = 3'b110,
    CMD_READ_MEM   = 3'b111
  } host_cmd_e;

  // Write-one-to-clear update; a set in the same cycle wins
  function automatic logic [WS_W-1:0] w1c(input logic [WS_W-1:0] cur,
                                          input logic [WS_W-1:0] set,
                                          input logic [WS_W-1:0] clr);
    w1c = (cur & ~clr) | set;
  endfunction

endpackage

// ---- inc/wake_if.sv ----
`timescale 1ns/100ps
interface wake_if;
  import wake_pkg::*;

  // Host to device controls
  logic              pme_en;
  logic              advanced_wake_enable;
  logic              advanced_pme_select;
  logic              active_state_advanced_wake;
  logic [WS_W-1:0]   wake_filter_control;
  logic [1:0]        power_state;
  logic              reset_power_state;
  logic              clr_pme_status;
  logic [WS_W-1:0]   clr_wake_status;
  logic [MEM_AW-1:0] mem_addr;

  // Device to host state
  logic              pme_status;
  logic [WS_W-1:0]   wake_status;
  logic [LEN_W-1:0]  wake_packet_length;
  logic [7:0]        mem_data;
  logic              pm_pme;

  // Open-drain wake request pin, pulled up when nobody drives it
  logic              wake_pin_out;
  logic              wake_pin_oe_n;
  logic              wake_request_pin;
  assign wake_request_pin = wake_pin_oe_n ? 1'b1 : wake_pin_out;

  modport device (
    input  pme_en, advanced_wake_enable, advanced_pme_select,
    input  active_state_advanced_wake, wake_filter_control, power_state,
    input  reset_power_state, clr_pme_status, clr_wake_status, mem_addr,
    output pme_status, wake_status, wake_packet_length, mem_data, pm_pme,
    output wake_pin_out, wake_pin_oe_n,
    input  wake_request_pin
  );

  modport host (
    output pme_en, advanced_wake_enable, advanced_pme_select,
    output active_state_advanced_wake, wake_filter_control, power_state,
    output reset_power_state, clr_pme_status, clr_wake_status, mem_addr,
    input  pme_status, wake_status, wake_packet_length, mem_data, pm_pme,
    input  wake_request_pin
  );

endinterface

// ---- verilog/wake_device.sv ----
`timescale 1ns/100ps
module wake_device
  import wake_pkg::*;
(
  // Clock, reset, enable
  input  wire logic               core_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               ce_i,
  // Link to host
  wake_if.device                  bus,
  // Receive byte stream
  input  wire logic               rx_valid_i,
  input  wire logic [7:0]         rx_data_i,
  input  wire logic               rx_last_i,
  input  wire logic               addr_pass_i,
  input  wire logic [FILT_N-1:0]  filter_match_i,
  input  wire logic [MAC_W-1:0]   station_addr_i,
  // Network link
  input  wire logic               link_change_i
);

  // ==========================================================================
  // Magic packet detector
  magic_state_e      state;
  magic_state_e      next_state;
  logic [2:0]        sync_cnt;
  logic [2:0]        next_sync_cnt;
  logic [2:0]        byte_idx;
  logic [2:0]        next_byte_idx;
  logic [3:0]        rep_cnt;
  logic [3:0]        next_rep_cnt;
  logic              found;
  logic              hit;
  logic [7:0]        exp_byte;
  logic              rx_take;
  logic              eop;

  assign rx_take = ce_i & rx_valid_i;
  assign eop     = rx_take & rx_last_i;
  assign exp_byte = station_addr_i[(MAC_W - 8) - 8 * int'(byte_idx) +: 8];

  always_comb
  begin
    next_state    = state;
    next_sync_cnt = sync_cnt;
    next_byte_idx = byte_idx;
    next_rep_cnt  = rep_cnt;
    hit           = 1'b0;
    case (state)
      MG_SYNC:
      begin
        if (rx_data_i == SYNC_BYTE)
        begin
          if (sync_cnt != SYNC_COUNT)
            next_sync_cnt = sync_cnt + 3'h1;
        end
        else if (sync_cnt == SYNC_COUNT && rx_data_i == exp_byte)
        begin
          next_state    = MG_ADDR;
          next_byte_idx = 3'h1;
          next_rep_cnt  = 4'h0;
          next_sync_cnt = 3'h0;
        end
        else
          next_sync_cnt = 3'h0;
      end
      MG_ADDR:
      begin
        if (rx_data_i == exp_byte)
        begin
          if (byte_idx == MAC_LAST)
          begin
            next_byte_idx = 3'h0;
            if (rep_cnt == REPS_LAST)
            begin
              hit        = 1'b1;
              next_state = MG_SYNC;
            end
            else
              next_rep_cnt = rep_cnt + 4'h1;
          end
          else
            next_byte_idx = byte_idx + 3'h1;
        end
        else
        begin
          next_state    = MG_SYNC;
          next_byte_idx = 3'h0;
          next_sync_cnt = (rx_data_i == SYNC_BYTE) ? 3'h1 : 3'h0;
        end
      end
      default:
      begin
        next_state    = MG_SYNC;
        next_sync_cnt = 3'h0;
      end
    endcase
  end

  // Every received byte runs through the detector
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state    <= MG_SYNC;
      sync_cnt <= 3'h0;
      byte_idx <= 3'h0;
      rep_cnt  <= 4'h0;
      found    <= 1'b0;
    end
    else if (rx_take)
    begin
      if (rx_last_i)
      begin
        state    <= MG_SYNC;
        sync_cnt <= 3'h0;
        byte_idx <= 3'h0;
        rep_cnt  <= 4'h0;
        found    <= 1'b0;
      end
      else
      begin
        state    <= next_state;
        sync_cnt <= next_sync_cnt;
        byte_idx <= next_byte_idx;
        rep_cnt  <= next_rep_cnt;
        found    <= found | hit;
      end
    end
  end

  // ==========================================================================
  // Wake decision at end of packet and on link change
  logic              pkt_magic;
  logic              power_ok;
  logic              apm_hit;
  logic              pkt_block;
  logic [WS_W-1:0]   pm_hits;
  logic              lnk_hit;
  logic [WS_W-1:0]   set_vec;
  logic              pkt_wake;
  logic              wake_evt;
  logic              pin_req;
  logic              store;

  assign pkt_magic = found | hit;
  assign power_ok  = bus.active_state_advanced_wake
                   | (bus.power_state == PS_D3)
                   | bus.reset_power_state;
  assign apm_hit   = eop & pkt_magic & bus.advanced_wake_enable
                   & (bus.advanced_pme_select | bus.pme_en)
                   & power_ok;
  assign pkt_block = |bus.wake_status[WS_W-1:WS_MAGIC];

  always_comb
  begin
    pm_hits = WS_RESET;
    if (eop && addr_pass_i && !pkt_block)
    begin
      pm_hits[WS_MAGIC] = pkt_magic & bus.wake_filter_control[WS_MAGIC];
      pm_hits[WS_W-1:WS_FILT0] = filter_match_i
        & bus.wake_filter_control[WS_W-1:WS_FILT0];
    end
  end

  assign lnk_hit = ce_i & link_change_i
                 & bus.wake_filter_control[WS_LINK_CHANGE_WAKE]
                 & ~bus.wake_status[WS_LINK_CHANGE_WAKE];

  always_comb
  begin
    set_vec           = pm_hits;
    set_vec[WS_MAGIC] = pm_hits[WS_MAGIC] | apm_hit;
    set_vec[WS_LINK_CHANGE_WAKE]  = lnk_hit;
  end

  // Both methods feed the same event, so a filter wake ignores ADVANCED_WAKE_ENABLE
  assign pkt_wake = apm_hit | (|pm_hits);
  assign wake_evt = pkt_wake | lnk_hit;
  assign pin_req  = apm_hit | (bus.pme_en & wake_evt);
  assign store    = pkt_wake & ~bus.wake_status[WS_MAGIC];

  // ==========================================================================
  // Packet length and capture memory (two banks, flipped on a stored wake)
  logic [LEN_W-1:0]  rx_len;
  logic [LEN_W-1:0]  pkt_len;
  logic              bank;
  logic [7:0]        mem [0:2*MEM_BYTES-1];

  assign pkt_len = (rx_len == LEN_MAX) ? LEN_MAX : rx_len + 14'h0001;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rx_len <= LEN_RESET;
    else if (rx_take)
      rx_len <= rx_last_i ? LEN_RESET : pkt_len;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rx_take && rx_len < LEN_W'(MEM_BYTES))
      mem[{~bank, rx_len[MEM_AW-1:0]}] <= rx_data_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bank <= 1'b0;
    else if (ce_i && store)
      bank <= ~bank;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bus.mem_data <= 8'h00;
    else if (ce_i)
      bus.mem_data <= mem[{bank, bus.mem_addr}];
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bus.wake_packet_length <= LEN_RESET;
    else if (pkt_wake)
      bus.wake_packet_length <= pkt_len;
  end

  // ==========================================================================
  // Status, PME and wake request pin
  logic              pme_en_q;
  logic              pin_on;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bus.wake_status <= WS_RESET;
    else if (ce_i)
      bus.wake_status <= w1c(bus.wake_status, set_vec,
                             bus.clr_wake_status);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bus.pme_status <= 1'b0;
    else if (ce_i)
      bus.pme_status <= wake_evt | (bus.pme_status & ~bus.clr_pme_status);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pme_en_q <= 1'b0;
    else if (ce_i)
      pme_en_q <= bus.pme_en;
  end

  // Each qualifying event raises the pin again and sends a message
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pin_on <= 1'b0;
    else if (ce_i)
    begin
      if (wake_evt && pin_req)
        pin_on <= 1'b1;
      else if (bus.clr_pme_status || (pme_en_q && !bus.pme_en))
        pin_on <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bus.pm_pme <= 1'b0;
    else if (ce_i)
      bus.pm_pme <= wake_evt & pin_req;
  end

  assign bus.wake_pin_out  = 1'b0;
  assign bus.wake_pin_oe_n = ~pin_on;

endmodule // wake_device

// ---- verilog/wake_host.sv ----
`timescale 1ns/100ps
module wake_host
  import wake_pkg::*;
(
  // Clock, reset, enable
  input  wire logic               core_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               ce_i,
  // Link to device
  wake_if.host                    bus,
  // Command port
  input  wire logic               cmd_valid_i,
  input  wire host_cmd_e          cmd_i,
  input  wire logic [15:0]        cmd_data_i,
  // Answers and mirrored state
  output logic                    rsp_valid_o,
  output logic [7:0]              rsp_data_o,
  output logic                    pme_status_o,
  output logic [WS_W-1:0]         wake_status_o,
  output logic [LEN_W-1:0]        wake_length_o,
  output logic                    wake_seen_o
);

  // ==========================================================================
  // Configuration side
  logic              take;
  logic              rd_p1;
  logic              rd_p2;

  assign take = ce_i & cmd_valid_i;

  // Select bit resets to zero so PME enable alone gates wake
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bus.pme_en                     <= 1'b0;
      bus.advanced_wake_enable       <= 1'b0;
      bus.advanced_pme_select        <= 1'b0;
      bus.active_state_advanced_wake <= 1'b0;
      bus.wake_filter_control        <= WS_RESET;
      bus.power_state                <= PS_D0;
      bus.reset_power_state          <= 1'b0;
      bus.mem_addr                   <= 7'h00;
    end
    else if (take)
    begin
      case (cmd_i)
        CMD_CTRL:
        begin
          bus.advanced_wake_enable       <= cmd_data_i[0];
          bus.advanced_pme_select        <= cmd_data_i[1];
          bus.active_state_advanced_wake <= cmd_data_i[2];
          if (cmd_data_i[0])
            bus.wake_filter_control <= WS_RESET;
        end
        CMD_PME_EN:
          bus.pme_en <= cmd_data_i[0];
        CMD_ARM:
        begin
          bus.pme_en               <= 1'b1;
          bus.advanced_wake_enable <= 1'b0;
          bus.wake_filter_control  <= cmd_data_i[WS_W-1:0];
          bus.power_state          <= PS_D3;
        end
        CMD_DISARM:
        begin
          bus.wake_filter_control <= WS_RESET;
          bus.power_state         <= PS_D0;
        end
        CMD_POWER:
        begin
          bus.power_state       <= cmd_data_i[1:0];
          bus.reset_power_state <= cmd_data_i[2];
        end
        CMD_READ_MEM:
          bus.mem_addr <= cmd_data_i[MEM_AW-1:0];
        default:
          bus.mem_addr <= bus.mem_addr;
      endcase
    end
  end

  // One-cycle clear strobes
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bus.clr_pme_status  <= 1'b0;
      bus.clr_wake_status <= WS_RESET;
    end
    else if (ce_i)
    begin
      bus.clr_pme_status <= take & (cmd_i == CMD_CLR_PME);
      if (take && (cmd_i == CMD_ARM || cmd_i == CMD_DISARM))
        bus.clr_wake_status <= {WS_W{1'b1}};
      else if (take && cmd_i == CMD_CLR_STATUS)
        bus.clr_wake_status <= cmd_data_i[WS_W-1:0];
      else
        bus.clr_wake_status <= WS_RESET;
    end
  end

  // ==========================================================================
  // Answers
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_p1         <= 1'b0;
      rd_p2         <= 1'b0;
      rsp_valid_o   <= 1'b0;
      rsp_data_o    <= 8'h00;
      pme_status_o  <= 1'b0;
      wake_status_o <= WS_RESET;
      wake_length_o <= LEN_RESET;
      wake_seen_o   <= 1'b0;
    end
    else if (ce_i)
    begin
      rd_p1         <= take & (cmd_i == CMD_READ_MEM);
      rd_p2         <= rd_p1;
      rsp_valid_o   <= rd_p2;
      if (rd_p2)
        rsp_data_o <= bus.mem_data;
      pme_status_o  <= bus.pme_status;
      wake_status_o <= bus.wake_status;
      wake_length_o <= bus.wake_packet_length;
      wake_seen_o   <= ~bus.wake_request_pin;
    end
  end

endmodule // wake_host

// ---- verification/wake_link_asserts.sv ----
`timescale 1ns/100ps
module wake_link_asserts
  import wake_pkg::*;
(
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  // Interface signals
  input  wire logic             pme_en,
  input  wire logic             advanced_pme_select,
  input  wire logic             clr_pme_status,
  input  wire logic [WS_W-1:0]  clr_wake_status,
  input  wire logic             pme_status,
  input  wire logic [WS_W-1:0]  wake_status,
  input  wire logic [LEN_W-1:0] wake_packet_length,
  input  wire logic             pm_pme,
  input  wire logic             wake_pin_oe_n
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ==========================================================================
  // Assertions
  pme_pulse_a: assert property (pm_pme |=> !pm_pme)
    else $error("pme message longer than one cycle");
  msg_status_a: assert property (pm_pme |-> pme_status)
    else $error("pme message without pme status");
  status_cause_a: assert property (
    (wake_status & ~$past(wake_status)) != '0 |-> pme_status)
    else $error("wake status set without pme status");
  pin_cause_a: assert property ($fell(wake_pin_oe_n) |-> pme_status)
    else $error("wake pin driven without pme status");
  pin_select_a: assert property (
    $fell(wake_pin_oe_n) && !pme_en |-> advanced_pme_select)
    else $error("wake pin driven while pme disabled");
  pin_hold_a: assert property (
    !wake_pin_oe_n && pme_en && !clr_pme_status |=> !wake_pin_oe_n)
    else $error("wake pin released early");
  pin_clear_a: assert property (
    clr_pme_status |=> (wake_pin_oe_n && !pme_status) || pm_pme)
    else $error("pme clear did not release pin");
  status_w1c_a: assert property (
    clr_wake_status != '0
      |=> (wake_status & $past(clr_wake_status)) == '0 || pm_pme)
    else $error("wake status not cleared by write of one");
  status_keep_a: assert property (
    ($past(wake_status) & ~wake_status & ~$past(clr_wake_status)) == '0)
    else $error("wake status bit dropped without clear");
  length_wake_a: assert property (
    $changed(wake_packet_length) |-> pme_status)
    else $error("length changed without wake");

  // ==========================================================================
  // Coverage
  pme_seen_c: cover property (pm_pme);
  pin_nopme_c: cover property ($fell(wake_pin_oe_n) && !pme_en);
  multi_filt_c: cover property ($countones(wake_status) > 1);
endmodule // wake_link_asserts

// ---- verification/tb_wake_up_management.sv ----
`timescale 1ns/100ps
module tb_wake_up_management;
  import wake_pkg::*;
  localparam logic [MAC_W-1:0] SA = 48'h0a1b_2c3d_4e5f;
  logic              core_clk_i;
  logic              rst_n_i;
  logic              ce_i;
  logic              cmd_valid_i;
  host_cmd_e         cmd_i;
  logic [15:0]       cmd_data_i;
  logic              rsp_valid_o;
  logic [7:0]        rsp_data_o;
  logic              pme_status_o;
  logic [WS_W-1:0]   wake_status_o;
  logic [LEN_W-1:0]  wake_length_o;
  logic              wake_seen_o;
  logic              rx_valid_i;
  logic [7:0]        rx_data_i;
  logic              rx_last_i;
  logic              addr_pass_i;
  logic [FILT_N-1:0] filter_match_i;
  logic              link_change_i;
  int                miscompares;
  int                comparisons;
  int                pulses;
  int                i;
  int                n;
  logic [2:0]        ctl_tab [5] = '{3'h1, 3'h3, 3'h7, 3'h3, 3'h2};
  logic [2:0]        pwr_tab [5] = '{3'h3, 3'h0, 3'h0, 3'h4, 3'h3};
  logic              hit_tab [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  wake_if bus ();

  wake_device i_wake_device (
    .core_clk_i     (core_clk_i),
    .rst_n_i        (rst_n_i),
    .ce_i           (ce_i),
    .bus            (bus),
    .rx_valid_i     (rx_valid_i),
    .rx_data_i      (rx_data_i),
    .rx_last_i      (rx_last_i),
    .addr_pass_i    (addr_pass_i),
    .filter_match_i (filter_match_i),
    .station_addr_i (SA),
    .link_change_i  (link_change_i)
  );

  wake_host i_wake_host (
    .core_clk_i    (core_clk_i),
    .rst_n_i       (rst_n_i),
    .ce_i          (ce_i),
    .bus           (bus),
    .cmd_valid_i   (cmd_valid_i),
    .cmd_i         (cmd_i),
    .cmd_data_i    (cmd_data_i),
    .rsp_valid_o   (rsp_valid_o),
    .rsp_data_o    (rsp_data_o),
    .pme_status_o  (pme_status_o),
    .wake_status_o (wake_status_o),
    .wake_length_o (wake_length_o),
    .wake_seen_o   (wake_seen_o)
  );

  wake_link_asserts i_wake_link_asserts (
    .core_clk_i          (core_clk_i),
    .rst_n_i             (rst_n_i),
    .pme_en              (bus.pme_en),
    .advanced_pme_select (bus.advanced_pme_select),
    .clr_pme_status      (bus.clr_pme_status),
    .clr_wake_status     (bus.clr_wake_status),
    .pme_status          (bus.pme_status),
    .wake_status         (bus.wake_status),
    .wake_packet_length  (bus.wake_packet_length),
    .pm_pme              (bus.pm_pme),
    .wake_pin_oe_n       (bus.wake_pin_oe_n)
  );

  // ==========================================================================
  // Clock, pulse counter, watchdog
  initial
  begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  always @(negedge core_clk_i)
    if (bus.pm_pme === 1'b1)
      pulses++;

  initial
  begin
    #400000;
    miscompares++;
    summarize();
  end

  // ==========================================================================
  // Tasks
  task automatic summarize();
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic st(input logic p, input logic [WS_W-1:0] s,
                    input logic w);
    chk("pme_status", 16'(p), 16'(pme_status_o));
    chk("wake_status", 16'(s), 16'(wake_status_o));
    chk("wake_pin", 16'(w), 16'(wake_seen_o));
  endtask

  task automatic cmd(input host_cmd_e c, input logic [15:0] d);
    @(negedge core_clk_i);
    cmd_valid_i = 1'b1;
    cmd_i = c;
    cmd_data_i = d;
    @(negedge core_clk_i);
    cmd_valid_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    int k;
    @(negedge core_clk_i);
    cmd_valid_i = 1'b1;
    cmd_i = CMD_READ_MEM;
    cmd_data_i = 16'(a);
    @(negedge core_clk_i);
    cmd_valid_i = 1'b0;
    k = 0;
    while (rsp_valid_o !== 1'b1 && k < 8)
    begin
      @(negedge core_clk_i);
      k++;
    end
    chk("read_valid", 16'h0001, 16'(rsp_valid_o));
    chk("mem_data", 16'(e), 16'(rsp_data_o));
  endtask

  // Magic body: lead bytes, six sync bytes, station address repeated
  task automatic pkt(input int lead, input int len, input bit magic,
                     input logic pass, input logic [FILT_N-1:0] m);
    int k;
    for (k = 0; k < len; k++)
    begin
      @(negedge core_clk_i);
      rx_valid_i = 1'b1;
      rx_last_i = (k == len - 1);
      addr_pass_i = pass;
      filter_match_i = m;
      if (k < lead || !magic)
        rx_data_i = k[7:0];
      else if (k < lead + 6)
        rx_data_i = SYNC_BYTE;
      else
        rx_data_i = SA[47 - 8 * ((k - lead - 6) % 6) -: 8];
    end
    @(negedge core_clk_i);
    rx_valid_i = 1'b0;
    rx_last_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
  endtask

  task automatic link();
    @(negedge core_clk_i);
    link_change_i = 1'b1;
    @(negedge core_clk_i);
    link_change_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    ce_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_i = CMD_CTRL;
    cmd_data_i = 16'h0000;
    rx_valid_i = 1'b0;
    rx_data_i = 8'h00;
    rx_last_i = 1'b0;
    addr_pass_i = 1'b0;
    filter_match_i = '0;
    link_change_i = 1'b0;
    miscompares = 0;
    comparisons = 0;
    pulses = 0;
    rst_n_i = 1'b0;
    repeat (8) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    chk("pin_idle", 16'h0001, 16'(bus.wake_request_pin));
    st(1'b0, 8'h00, 1'b0);
    // Enable, select and power state combinations
    for (i = 0; i < 5; i++)
    begin
      cmd(CMD_CTRL, 16'(ctl_tab[i]));
      cmd(CMD_POWER, 16'(pwr_tab[i]));
      n = pulses;
      pkt(i, i + 102, 1'b1, 1'b1, '0);
      chk("pulses", 16'(n + int'(hit_tab[i])), 16'(pulses));
      st(hit_tab[i], {6'h00, hit_tab[i], 1'b0}, hit_tab[i]);
      cmd(CMD_CLR_PME, 16'h0000);
      cmd(CMD_CLR_STATUS, 16'h00ff);
    end
    // Capture, lock and repeated magic events
    cmd(CMD_CTRL, 16'h0003);
    cmd(CMD_POWER, 16'h0003);
    pkt(0, 102, 1'b1, 1'b1, '0);
    chk("length", 16'd102, 16'(wake_length_o));
    rd(7'h00, SYNC_BYTE);
    rd(7'h06, SA[47:40]);
    n = pulses;
    pkt(3, 105, 1'b1, 1'b1, '0);
    chk("pulses", 16'(n + 1), 16'(pulses));
    rd(7'h00, SYNC_BYTE);
    cmd(CMD_CLR_STATUS, 16'h0000);
    st(1'b1, 8'h02, 1'b1);
    cmd(CMD_CLR_PME, 16'h0000);
    st(1'b0, 8'h02, 1'b0);
    cmd(CMD_CTRL, 16'h0000);
    // Filter and link change wakes
    cmd(CMD_ARM, 16'h000d);
    pkt(0, 200, 1'b0, 1'b1, 6'h07);
    st(1'b1, 8'h0c, 1'b1);
    chk("length", 16'd200, 16'(wake_length_o));
    rd(7'h7f, 8'h7f);
    pkt(0, 50, 1'b0, 1'b1, 6'h01);
    chk("length", 16'd200, 16'(wake_length_o));
    link();
    st(1'b1, 8'h0d, 1'b1);
    cmd(CMD_CLR_STATUS, 16'h000c);
    pkt(0, 40, 1'b0, 1'b0, 6'h01);
    pkt(0, 40, 1'b0, 1'b1, 6'h04);
    st(1'b1, 8'h01, 1'b1);
    pkt(0, 60, 1'b0, 1'b1, 6'h01);
    st(1'b1, 8'h05, 1'b1);
    chk("length", 16'd60, 16'(wake_length_o));
    cmd(CMD_PME_EN, 16'h0000);
    st(1'b1, 8'h05, 1'b0);
    cmd(CMD_CLR_STATUS, 16'h00ff);
    cmd(CMD_CLR_PME, 16'h0000);
    link();
    st(1'b1, 8'h01, 1'b0);
    cmd(CMD_DISARM, 16'h0000);
    st(1'b1, 8'h00, 1'b0);
    // Frozen link change, then magic through the filter path
    cmd(CMD_ARM, 16'h0003);
    ce_i = 1'b0;
    link();
    ce_i = 1'b1;
    pkt(0, 102, 1'b1, 1'b1, '0);
    st(1'b1, 8'h02, 1'b1);
    chk("length", 16'h0066, 16'(wake_length_o));
    summarize();
  end
endmodule // tb_wake_up_management
